// [shared/cct_pkg.sv]
// constants, types and register map of the core cycle timing control block
package cct_pkg;
    // ==============================================================
    // timing
    localparam int CCT_CLOCK_HZ = 40_000_000;
    localparam int CCT_CLOCK_PERIOD_NS = 25;
    localparam int CCT_NORMAL_CLOCKS = 1;
    localparam int CCT_SLOW_CLOCKS = 1024;
    localparam int CCT_LEGACY_TIMER_CLOCKS = 12;
    localparam int CCT_STRETCH_MAX = 10;
    localparam int CCT_TIMERS = 3;
    localparam int CCT_EXEC_CYCLES = 1;
    localparam int CCT_XDM_READ_CYCLES = 2;
    localparam int CCT_MOV_DD_CYCLES = 3;
    localparam logic [1:0] CCT_STRAP_CAPTURE = 2'h2;

    // ==============================================================
    // register bus
    localparam int CCT_ADDR_W = 4;
    localparam int CCT_DATA_W = 8;
    localparam logic [3:0] CCT_OFF_CTRL = 4'h0;
    localparam logic [3:0] CCT_OFF_TRATE = 4'h1;
    localparam logic [3:0] CCT_OFF_STRETCH = 4'h2;
    localparam logic [3:0] CCT_OFF_STATUS = 4'h3;
    localparam int CCT_CTRL_SLOW = 0;
    localparam int CCT_CTRL_SWITCHBACK = 1;
    localparam int CCT_CTRL_ALE_QUIET = 2;
    localparam int CCT_STAT_SLOW = 0;
    localparam int CCT_STAT_EXTPROG = 1;
    localparam int CCT_STAT_XBUSY = 2;
    localparam int CCT_STAT_IBUSY = 3;
    localparam logic [2:0] CCT_CTRL_RST = 3'h0;
    localparam logic [2:0] CCT_TRATE_RST = 3'h0;
    localparam logic [3:0] CCT_STRETCH_RST = 4'h0;

    // ==============================================================
    // types
    typedef enum logic [1:0] {CCT_INS_PLAIN, CCT_INS_XDM_READ, CCT_INS_MOV_DD} cct_ins_kind_e;
    typedef enum logic [1:0] {CCT_XS_IDLE, CCT_XS_ADDR, CCT_XS_STROBE} cct_xdm_state_e;
    typedef struct packed {
        logic start;
        logic [1:0] bytes;
        cct_ins_kind_e kind;
    } cct_instr_s;
    typedef struct packed {
        logic valid;
        logic write;
    } cct_xdm_req_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cct_bus_s;
endpackage

// [hw/cct_core_cycle_timing_control.sv]
// machine cycle, timer rate, external access and program source control
// Operation
// R1: in normal speed one machine cycle lasts a single oscillator clock
// R2: reduced-rate power mode stretches each machine cycle to 1024 clocks
// R3: with switchback enabled, a pending interrupt cancels reduced-rate power mode
// R4: emission reduction keeps the address-latch strobe idle without external access
// R5: external data moves stretch by a programmable 0 to 10 machine cycles
// R6: after reset every timer increments once per 12 oscillator clocks
// R7: each timer can independently increment once per oscillator clock
// R8: program source pin low fetches externally, high fetches from internal flash
// R9: instructions take one machine cycle per byte plus one for execution
// R10: pointer external read takes two cycles, direct-to-direct move takes three
// R11: port C bits four to seven carry timer inputs and data strobes
// R12: architectural bits and flags stay untouched; only cycle counts change
`timescale 1ns/10ps
`default_nettype none
module cct_core_cycle_timing_control
    import cct_pkg::*;
#(
    parameter int SLOW_CLOCKS = CCT_SLOW_CLOCKS,
    parameter int TIMER_CLOCKS = CCT_LEGACY_TIMER_CLOCKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire cct_bus_s bus,
    output logic [CCT_DATA_W-1:0] rdData,
    // core side
    input wire cct_instr_s instr,
    input wire cct_xdm_req_s xdmReq,
    input wire logic progFetch,
    input wire logic irqPending,
    output logic cycleTick,
    output logic instrDone,
    output logic xdmDone,
    output logic [CCT_TIMERS-1:0] timerTick,
    output logic extCountA,
    output logic extCountB,
    output logic extProgram,
    // pins
    input wire logic program_source_select_pin,
    input wire logic port_c_bit_four,
    input wire logic port_c_bit_five,
    output logic aleOut,
    output logic portCSixOut,
    output logic portCSixOe_n,
    output logic portCSevenOut,
    output logic portCSevenOe_n
);
    // ==============================================================
    // local constants
    localparam int DIV_W = $clog2(SLOW_CLOCKS);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_CLOCKS - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
    localparam int PRE_W = $clog2(TIMER_CLOCKS);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TIMER_CLOCKS - 1);
    localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);
    localparam logic [3:0] STRETCH_TOP = 4'(CCT_STRETCH_MAX);
    localparam logic [3:0] CNT_ONE = 4'h1;

    // keep stored stretch inside the supported range
    function automatic logic [3:0] clampStretch(input logic [3:0] v);
        clampStretch = (v > STRETCH_TOP) ? STRETCH_TOP : v;
    endfunction

    // machine cycles an instruction occupies, stretch included for external reads
    function automatic logic [3:0] instrCycles(input cct_instr_s i, input logic [3:0] s);
        unique case (i.kind)
            CCT_INS_XDM_READ: instrCycles = 4'(CCT_XDM_READ_CYCLES) + s; // R10
            CCT_INS_MOV_DD: instrCycles = 4'(CCT_MOV_DD_CYCLES); // R10
            default: instrCycles = 4'({2'h0, i.bytes}) + 4'(CCT_EXEC_CYCLES); // R9
        endcase
    endfunction

    // ==============================================================
    // registers
    logic [2:0] ctrl_q;
    logic [CCT_TIMERS-1:0] timerFast_q;
    logic [3:0] stretch_q;
    logic [DIV_W-1:0] divCnt_q;
    logic [PRE_W-1:0] pre_q;
    logic [3:0] iRem_q;
    logic iBusy_q;
    cct_xdm_state_e xState_q;
    logic [3:0] xWait_q;
    logic xWrite_q;
    logic srcSync1_q, srcSync2_q;
    logic [1:0] startCnt_q;
    logic startDone_q;
    logic [2:0] t4Sync_q, t5Sync_q;
    logic slowActive, switchbackEn, aleQuiet, mcEn, legacyTick, instrAccept, ctrlWrite;

    assign slowActive = ctrl_q[CCT_CTRL_SLOW];
    assign switchbackEn = ctrl_q[CCT_CTRL_SWITCHBACK];
    assign aleQuiet = ctrl_q[CCT_CTRL_ALE_QUIET];
    assign ctrlWrite = bus.wr && (bus.addr == CCT_OFF_CTRL);
    // one enable per machine cycle; every clock at normal speed
    assign mcEn = !slowActive || (divCnt_q == DIV_LAST); // R1 R2
    assign legacyTick = (pre_q == PRE_LAST);
    assign instrAccept = instr.start && !iBusy_q;

    // ==============================================================
    // control register; a software write beats the switchback clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CCT_CTRL_RST;
        end else if (ctrlWrite) begin
            ctrl_q <= bus.wdata[2:0];
        end else if (slowActive && switchbackEn && irqPending) begin
            ctrl_q[CCT_CTRL_SLOW] <= 1'b0; // R3
        end
    end

    // timer rate and stretch registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timerFast_q <= CCT_TRATE_RST; // R6
            stretch_q <= CCT_STRETCH_RST;
        end else if (bus.wr) begin
            if (bus.addr == CCT_OFF_TRATE) begin
                timerFast_q <= bus.wdata[CCT_TIMERS-1:0]; // R7
            end
            if (bus.addr == CCT_OFF_STRETCH) begin
                stretch_q <= clampStretch(bus.wdata[3:0]); // R5
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= '0;
        end else if (bus.rd) begin
            unique case (bus.addr)
                CCT_OFF_CTRL: rdData <= {5'h0, ctrl_q};
                CCT_OFF_TRATE: rdData <= {5'h0, timerFast_q};
                CCT_OFF_STRETCH: rdData <= {4'h0, stretch_q};
                CCT_OFF_STATUS: rdData <= {4'h0, iBusy_q, xState_q != CCT_XS_IDLE,
                                           extProgram, slowActive};
                default: rdData <= '0; // unmapped reads as zero
            endcase
        end else begin
            rdData <= '0;
        end
    end

    // ==============================================================
    // machine cycle divider, held at zero at normal speed
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            divCnt_q <= '0;
        end else if (!slowActive || divCnt_q == DIV_LAST) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + DIV_ONE; // R2
        end
    end

    // cycle tick as seen by the core, one clock late
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cycleTick <= 1'b0;
        end else begin
            cycleTick <= mcEn; // R1
        end
    end

    // ==============================================================
    // timer prescaler runs off the oscillator so legacy rates ignore the power mode
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
        end else if (legacyTick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_ONE; // R6
        end
    end

    // per timer choice of legacy or single-clock increment
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timerTick <= '0;
        end else begin
            for (int i = 0; i < CCT_TIMERS; i++) begin
                timerTick[i] <= timerFast_q[i] | legacyTick; // R6 R7
            end
        end
    end

    // ==============================================================
    // instruction duration counter; timing only, no architectural state here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            iRem_q <= '0;
            iBusy_q <= 1'b0;
            instrDone <= 1'b0;
        end else begin
            instrDone <= 1'b0;
            if (instrAccept) begin
                iRem_q <= instrCycles(instr, stretch_q); // R9 R10 R12
                iBusy_q <= 1'b1;
            end else if (iBusy_q && mcEn) begin
                if (iRem_q <= CNT_ONE) begin
                    iBusy_q <= 1'b0;
                    instrDone <= 1'b1;
                end else begin
                    iRem_q <= iRem_q - CNT_ONE;
                end
            end
        end
    end

    // ==============================================================
    // external data move: address phase then strobe for one plus stretch cycles
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            xState_q <= CCT_XS_IDLE;
            xWait_q <= '0;
            xWrite_q <= 1'b0;
            xdmDone <= 1'b0;
        end else begin
            xdmDone <= 1'b0;
            unique case (xState_q)
                CCT_XS_IDLE: begin
                    if (xdmReq.valid) begin
                        xState_q <= CCT_XS_ADDR;
                        xWrite_q <= xdmReq.write;
                    end
                end
                CCT_XS_ADDR: begin
                    if (mcEn) begin
                        xState_q <= CCT_XS_STROBE;
                        xWait_q <= stretch_q; // R5
                    end
                end
                CCT_XS_STROBE: begin
                    if (mcEn) begin
                        if (xWait_q == 4'h0) begin
                            xState_q <= CCT_XS_IDLE;
                            xdmDone <= 1'b1;
                        end else begin
                            xWait_q <= xWait_q - CNT_ONE; // R5
                        end
                    end
                end
                default: xState_q <= CCT_XS_IDLE;
            endcase
        end
    end

    // strobes on port C six and seven, always driven as outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            portCSixOut <= 1'b1;
            portCSevenOut <= 1'b1;
            portCSixOe_n <= 1'b0;
            portCSevenOe_n <= 1'b0;
        end else begin
            portCSixOut <= !(xState_q == CCT_XS_STROBE && xWrite_q); // R11
            portCSevenOut <= !(xState_q == CCT_XS_STROBE && !xWrite_q); // R11
            portCSixOe_n <= 1'b0;
            portCSevenOe_n <= 1'b0;
        end
    end

    // address latch strobe; quiet mode saves emissions at the cost of legacy probes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aleOut <= 1'b0;
        end else begin
            aleOut <= (xState_q == CCT_XS_ADDR) || (progFetch && extProgram)
                      || (!aleQuiet && mcEn); // R4
        end
    end

    // ==============================================================
    // program source pin: synchronised, then caught once after reset release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            srcSync1_q <= 1'b1;
            srcSync2_q <= 1'b1;
        end else begin
            srcSync1_q <= program_source_select_pin;
            srcSync2_q <= srcSync1_q;
        end
    end

    // strap capture waits for the synchroniser to fill
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            startCnt_q <= '0;
            startDone_q <= 1'b0;
            extProgram <= 1'b0;
        end else if (!startDone_q) begin
            if (startCnt_q == CCT_STRAP_CAPTURE) begin
                extProgram <= !srcSync2_q; // R8
                startDone_q <= 1'b1;
            end else begin
                startCnt_q <= startCnt_q + 2'h1;
            end
        end
    end

    // ==============================================================
    // timer external inputs, counted on a falling edge after synchronising
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t4Sync_q <= '1;
            t5Sync_q <= '1;
            extCountA <= 1'b0;
            extCountB <= 1'b0;
        end else begin
            t4Sync_q <= {t4Sync_q[1:0], port_c_bit_four};
            t5Sync_q <= {t5Sync_q[1:0], port_c_bit_five};
            extCountA <= t4Sync_q[2] && !t4Sync_q[1]; // R11
            extCountB <= t5Sync_q[2] && !t5Sync_q[1]; // R11
        end
    end

    // ==============================================================
    // checks
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic [DIV_W:0] gapCnt_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gapCnt_q <= '0;
        end else if (mcEn) begin
            gapCnt_q <= '0;
        end else begin
            gapCnt_q <= gapCnt_q + (DIV_W + 1)'(1);
        end
    end

    a_fast_cycle: assert property (!slowActive ##1 !slowActive |=> cycleTick) // R1
        else $error("machine cycle not one clock at normal speed");
    a_slow_cycle: assert property (mcEn && slowActive |-> // R2
        gapCnt_q == (DIV_W + 1)'(SLOW_CLOCKS - 1)) else $error("slow cycle length wrong");
    a_switch_back: assert property (slowActive && switchbackEn && irqPending // R3
        && !ctrlWrite |=> !slowActive) else $error("switchback did not leave slow mode");
    a_ale_quiet: assert property (aleQuiet && xState_q == CCT_XS_IDLE // R4
        && !(progFetch && extProgram) |=> !aleOut) else $error("latch strobe without access");
    a_stretch_end: assert property (xState_q == CCT_XS_STROBE && mcEn && xWait_q == 4'h0 // R5
        |=> xdmDone && xState_q == CCT_XS_IDLE) else $error("move did not end after stretch");
    a_stretch_cap: assert property (stretch_q <= STRETCH_TOP && xWait_q <= STRETCH_TOP) // R5
        else $error("stretch beyond maximum");
    a_legacy_gap: assert property (legacyTick |=> !legacyTick [*8]) // R6
        else $error("legacy timer tick too early");
    a_legacy_period: assert property (legacyTick |-> ##12 legacyTick) // R6
        else $error("legacy timer tick not every twelve clocks");
    a_fast_timer: assert property (timerFast_q[0] |=> timerTick[0]) // R7
        else $error("fast timer missed a clock");
    a_prog_source: assert property (!startDone_q && startCnt_q == CCT_STRAP_CAPTURE // R8
        |=> extProgram == !$past(srcSync2_q)) else $error("program source not from pin");
    a_xdm_read_len: assert property ((instrAccept && instr.kind == CCT_INS_XDM_READ // R10
        && stretch_q == 4'h0 && !slowActive) ##1 !slowActive [*2] |=> instrDone)
        else $error("pointer external read not two cycles");
    a_mov_dd_len: assert property ((instrAccept && instr.kind == CCT_INS_MOV_DD // R10
        && !slowActive) ##1 (!slowActive && !instrDone) [*3] |=> instrDone)
        else $error("direct move not three cycles");
    a_strobe_pin: assert property (xState_q == CCT_XS_STROBE && !xWrite_q // R11
        |=> !portCSevenOut && portCSixOut) else $error("read strobe not on port C bit seven");
endmodule
`default_nettype wire

// [tb/cct_ext_mem_model.sv]
// external memory and peripheral model at the far side of the timing block
`timescale 1ns/10ps
`default_nettype none
module cct_ext_mem_model #(
    parameter bit EXT_PROG = 1'b1
) (
    // clock
    input wire logic clock,
    // strobes from the block
    input wire logic wrPin,
    input wire logic wrOe_n,
    input wire logic rdPin,
    input wire logic rdOe_n,
    // commands from the bench
    input wire logic kickA,
    input wire logic kickB,
    // pins toward the block
    output logic progPin,
    output logic countPinA,
    output logic countPinB,
    // measured strobe widths in clocks
    output int rdWidth,
    output int wrWidth
);
    // ==============================================================
    // pins
    logic wrLine;
    logic rdLine;
    int rdRun;
    int wrRun;
    int holdA;
    int holdB;
    // strap tied low selects external program fetch
    assign progPin = !EXT_PROG;
    // a released strobe floats up through the pull-up, never keeps its last level
    assign wrLine = wrOe_n ? 1'b1 : wrPin;
    assign rdLine = rdOe_n ? 1'b1 : rdPin;
    // count pins idle high on their pull-ups, pulled low for 4 clocks on a kick
    assign countPinA = (holdA == 0);
    assign countPinB = (holdB == 0);
    // ==============================================================
    // strobe width capture, a slow device relies on the full stretch
    always @(posedge clock) begin
        if (!rdLine) begin
            rdRun <= rdRun + 1;
        end else if (rdRun != 0) begin
            rdWidth <= rdRun;
            rdRun <= 0;
        end
        if (!wrLine) begin
            wrRun <= wrRun + 1;
        end else if (wrRun != 0) begin
            wrWidth <= wrRun;
            wrRun <= 0;
        end
        holdA <= kickA ? 4 : (holdA != 0 ? holdA - 1 : 0);
        holdB <= kickB ? 4 : (holdB != 0 ? holdB - 1 : 0);
    end
endmodule
`default_nettype wire

// [tb/cct_core_cycle_timing_control_tb_top.sv]
// self-checking bench for the cycle timing control block
`timescale 1ns/10ps
`default_nettype none
module cct_core_cycle_timing_control_tb_top;
    import cct_pkg::*;
    localparam int SLOW_N = 16;
    // ==============================================================
    // signals
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    cct_bus_s bus = '0;
    cct_instr_s instr = '0;
    cct_xdm_req_s xdmReq = '0;
    logic progFetch = 1'b0;
    logic irqPending = 1'b0;
    logic kickA = 1'b0;
    logic kickB = 1'b0;
    logic [7:0] rdData;
    logic [2:0] timerTick;
    logic cycleTick, instrDone, xdmDone, extCountA, extCountB, extProgram;
    logic aleOut, wrPin, wrOe_n, rdPin, rdOe_n, progPin, pinA, pinB;
    int rdWidth, wrWidth;
    int miscompares = 0;
    int comparisons = 0;
    int regModel [4] = '{0, 0, 0, 2};
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((exp) !== (got)) begin \
            miscompares++; \
            $display("Error %s expected %0h seen %0h", name, exp, got); \
        end \
    end
    // free-running 40 MHz clock
    always #12.5 clock = ~clock;
    // ==============================================================
    // design and far side
    cct_core_cycle_timing_control #(.SLOW_CLOCKS(SLOW_N),
            .TIMER_CLOCKS(CCT_LEGACY_TIMER_CLOCKS)) DUT (
        .clock(clock), .arst_n(arst_n), .bus(bus), .rdData(rdData), .instr(instr),
        .xdmReq(xdmReq), .progFetch(progFetch), .irqPending(irqPending),
        .cycleTick(cycleTick), .instrDone(instrDone), .xdmDone(xdmDone),
        .timerTick(timerTick), .extCountA(extCountA), .extCountB(extCountB),
        .extProgram(extProgram), .program_source_select_pin(progPin),
        .port_c_bit_four(pinA), .port_c_bit_five(pinB), .aleOut(aleOut),
        .portCSixOut(wrPin), .portCSixOe_n(wrOe_n), .portCSevenOut(rdPin),
        .portCSevenOe_n(rdOe_n));
    cct_ext_mem_model #(.EXT_PROG(1'b1)) memModel (
        .clock(clock), .wrPin(wrPin), .wrOe_n(wrOe_n), .rdPin(rdPin), .rdOe_n(rdOe_n),
        .kickA(kickA), .kickB(kickB), .progPin(progPin), .countPinA(pinA),
        .countPinB(pinB), .rdWidth(rdWidth), .wrWidth(wrWidth));
    // ==============================================================
    // tasks
    // register write, mirrored into the model with the stretch clamp
    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
        if (a == CCT_OFF_STRETCH) regModel[2] = (d > 10) ? 10 : int'(d);
        else if (a < CCT_OFF_STATUS) regModel[a] = int'(d & 8'h07);
    endtask
    // register read, data only in the cycle after the strobe
    task automatic regChk(input logic [3:0] a, input int expd);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        `CHK("rdData", expd, rdData)
        @(posedge clock);
        #1;
        `CHK("rdData idle", 0, rdData)
    endtask
    // count high samples of one output over n clocks
    task automatic countHigh(input int sel, input int n, output int cnt);
        logic [6:0] v;
        cnt = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            v = {timerTick, extCountB, extCountA, aleOut, cycleTick};
            cnt += $isunknown(v[sel]) ? 1000 : int'(v[sel]); // an unknown spoils the count
        end
    endtask
    // issue an instruction or external move and measure clocks to done
    task automatic runOp(input bit xdm, input cct_ins_kind_e k, input logic [1:0] b,
            input int expd);
        int n;
        n = 0;
        @(posedge clock);
        if (xdm) begin
            xdmReq <= '{valid: 1'b1, write: b[0]};
        end else begin
            instr <= '{start: 1'b1, bytes: b, kind: k};
        end
        @(posedge clock);
        xdmReq.valid <= 1'b0;
        instr.start <= 1'b0;
        #1;
        while ((xdm ? xdmDone : instrDone) !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("done delay", expd, n)
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==============================================================
    // watchdog, far beyond the few hundred clocks the tests need
    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        wrap_up();
    end
    // ==============================================================
    // main sequence
    initial begin
        int s, c, t, w;
        void'($urandom(32'hb41d6ca1));
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        repeat (6) @(posedge clock);
        regChk(CCT_OFF_CTRL, regModel[0]);
        regChk(CCT_OFF_TRATE, regModel[1]);
        regChk(CCT_OFF_STRETCH, regModel[2]);
        regChk(CCT_OFF_STATUS, regModel[3]);
        regChk(4'h9, 0);
        `CHK("extProgram", 1'b1, extProgram)
        countHigh(0, 20, c);
        `CHK("cycleTick", 20, c)
        countHigh(1, 20, c);
        `CHK("ale active", 1, int'(c > 0))
        // legacy timer rate, then a random mix of fast timers
        for (int i = 0; i < 3; i++) begin
            countHigh(4 + i, 24, c);
            `CHK("timer slow", 2, c)
        end
        t = $urandom_range(7, 1);
        regWr(CCT_OFF_TRATE, t[7:0]);
        regChk(CCT_OFF_TRATE, regModel[1]);
        for (int i = 0; i < 3; i++) begin
            countHigh(4 + i, 24, c);
            `CHK("timer rate", t[i] ? 24 : 2, c)
        end
        // instruction lengths, one cycle per byte plus execution, then direct move and pointer external read
        for (int b = 1; b < 4; b++) begin
            runOp(1'b0, CCT_INS_PLAIN, b[1:0], b + CCT_EXEC_CYCLES);
        end
        runOp(1'b0, CCT_INS_MOV_DD, 2'h3, CCT_MOV_DD_CYCLES);
        runOp(1'b0, CCT_INS_XDM_READ, 2'h1, CCT_XDM_READ_CYCLES);
        // stretch clamp and stretched moves, maximum first
        regWr(CCT_OFF_STRETCH, 8'h0f);
        regChk(CCT_OFF_STRETCH, regModel[2]);
        for (int i = 0; i < 4; i++) begin
            s = (i == 0) ? 10 : $urandom_range(10, 0);
            w = $urandom_range(1, 0);
            regWr(CCT_OFF_STRETCH, s[7:0]);
            runOp(1'b1, CCT_INS_PLAIN, w[1:0], 2 + s);
            repeat (2) @(posedge clock);
            #1;
            `CHK("strobe width", 1 + s, w ? wrWidth : rdWidth)
            runOp(1'b0, CCT_INS_XDM_READ, 2'h1, CCT_XDM_READ_CYCLES + s);
        end
        // quiet address latch strobe unless an external access runs
        regWr(CCT_OFF_STRETCH, 8'h00);
        regWr(CCT_OFF_CTRL, 8'h04);
        repeat (3) @(posedge clock);
        countHigh(1, 20, c);
        `CHK("ale quiet", 0, c)
        fork
            runOp(1'b1, CCT_INS_PLAIN, 2'h0, 2);
            countHigh(1, 6, c);
        join
        `CHK("ale on move", 1, int'(c > 0))
        @(posedge clock);
        progFetch <= 1'b1;
        countHigh(1, 8, c);
        `CHK("ale on fetch", 1, int'(c > 0))
        @(posedge clock);
        progFetch <= 1'b0;
        // reduced-rate mode, then switchback on a pending interrupt
        regWr(CCT_OFF_CTRL, 8'h01);
        regChk(CCT_OFF_STATUS, 3);
        repeat (2 * SLOW_N) @(posedge clock);
        countHigh(0, 4 * SLOW_N, c);
        `CHK("slow ticks", 4, c)
        regWr(CCT_OFF_CTRL, 8'h03);
        irqPending <= 1'b1;
        repeat (3) @(posedge clock);
        regModel[0] = 2;
        regChk(CCT_OFF_CTRL, regModel[0]);
        countHigh(0, 10, c);
        `CHK("fast again", 10, c)
        @(posedge clock);
        irqPending <= 1'b0;
        // external count inputs on their falling edges
        kickA <= 1'b1;
        @(posedge clock);
        kickA <= 1'b0;
        countHigh(2, 10, c);
        `CHK("countA", 1, c)
        @(posedge clock);
        kickB <= 1'b1;
        @(posedge clock);
        kickB <= 1'b0;
        countHigh(3, 10, c);
        `CHK("countB", 1, c)
        wrap_up();
    end
endmodule
`default_nettype wire
